/* File: inc/shc_pkg.sv */
// shc_pkg: constants, register map and state types of the standby controller
package shc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W            = 16;
    localparam int          DATA_W            = 8;
    localparam logic [15:0] REG_SETTLE_SELECT = 16'hfff4;
    localparam logic [15:0] REG_STANDBY_STAT  = 16'hfff5;
    localparam int          SEL_LO_BIT        = 0;
    localparam int          SEL_HI_BIT        = 1;
    localparam logic [1:0]  SETTLE_SEL_RESET  = 2'h3;
    localparam int          STAT_HALT_BIT     = 0;
    localparam int          STAT_STOP_BIT     = 1;
    localparam int          STAT_SETTLE_BIT   = 2;
    localparam int          STAT_RUN_BIT      = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 40;
    localparam int CNT_W           = 18;
    localparam int SETTLE_EXP0     = 10;
    localparam int SETTLE_EXP1     = 12;
    localparam int SETTLE_EXP2     = 15;
    localparam int SETTLE_EXP3     = 17;
    localparam int SETTLE_CYC0     = 1 << SETTLE_EXP0;
    localparam int SETTLE_CYC1     = 1 << SETTLE_EXP1;
    localparam int SETTLE_CYC2     = 1 << SETTLE_EXP2;
    localparam int SETTLE_CYC3     = 1 << SETTLE_EXP3;
    localparam int STOP_HOLD_US    = 34;
    localparam int STOP_HOLD_CYC   = STOP_HOLD_US * CLK_MHZ;
    localparam int OPTBYTE_US      = 544;
    localparam int OPTBYTE_CYC     = OPTBYTE_US * CLK_MHZ;
    localparam int WAKE_VEC_CLK    = 11;
    localparam int WAKE_NEXT_CLK   = 3;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_BOOT_OSC,
        MODE_BOOT_OPT,
        MODE_RUN,
        MODE_HALT,
        MODE_HALT_WAKE,
        MODE_STOP,
        MODE_STOP_OSC,
        MODE_STOP_SETTLE,
        MODE_STOP_HOLD
    } shc_mode_type;

    typedef struct packed {
        shc_mode_type mode;
        logic [1:0]   settle_sel;
        logic         osc_sync1;
        logic         osc_sync2;
        logic         cpu_clk_en;
        logic         osc_stop;
        logic         port_hold;
        logic         lsosc_keep;
        logic         wake_vec;
        logic         wake_next;
        logic         take_vec;
        logic [7:0]   rdata;
    } shc_state_type;

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } shc_cnt_state_type;

endpackage

/* File: src/shc_wait_counter.sv */
// shc_wait_counter: loadable down counter that times the option byte, settle, stop and halt wake waits
module shc_wait_counter #(
    parameter int W = 18
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] load_val_in,
    output logic              zero_out
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load_in) begin
            next_count = load_val_in;
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // a load of n-1 makes zero appear n-1 cycles after the load edge; registered count
    // only, since the caller may load on zero and must not see its own load here
    assign zero_out = (count == '0);

endmodule

/* File: src/shc_standby_ctrl.sv */
// shc_standby_ctrl: halt/stop standby sequencer with oscillator settle timing
//
// Chosen here: the plain strobed port.
module shc_standby_ctrl #(
    parameter int SETTLE_CYC0 = shc_pkg::SETTLE_CYC0,
    parameter int SETTLE_CYC1 = shc_pkg::SETTLE_CYC1,
    parameter int SETTLE_CYC2 = shc_pkg::SETTLE_CYC2,
    parameter int SETTLE_CYC3 = shc_pkg::SETTLE_CYC3,
    parameter int OPTBYTE_CYC = shc_pkg::OPTBYTE_CYC
) (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic [shc_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [shc_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    input  wire logic                        halt_cmd_in,
    input  wire logic                        stop_cmd_in,
    input  wire logic                        int_pending_in,
    input  wire logic                        int_accept_enable_in,
    input  wire logic                        clk_src_xtal_in,
    input  wire logic                        lsosc_on_in,
    input  wire logic                        osc_started_in,
    output logic [shc_pkg::DATA_W-1:0]       rdata_out,
    output logic                             cpu_clk_en_out,
    output logic                             osc_stop_out,
    output logic                             port_hold_out,
    output logic                             lsosc_keep_out,
    output logic                             wake_vec_out,
    output logic                             wake_next_out
);

    // ------------------------------------------------------------
    // state and wait counter
    // ------------------------------------------------------------
    shc_pkg::shc_state_type          st;
    shc_pkg::shc_state_type          next_st;
    logic                            cnt_load;
    logic [shc_pkg::CNT_W-1:0]       cnt_val;
    logic                            cnt_zero;
    logic                            osc_ok;

    shc_wait_counter #(
        .W (shc_pkg::CNT_W)
    ) u_wait (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .load_in     (cnt_load),
        .load_val_in (cnt_val),
        .zero_out    (cnt_zero)
    );

    assign osc_ok = st.osc_sync2;

    // selected settle wait minus one, as loaded into the counter
    function automatic logic [shc_pkg::CNT_W-1:0] settle_load(input logic [1:0] sel);
        logic [shc_pkg::CNT_W-1:0] v;
        case (sel)
            2'h0: v = shc_pkg::CNT_W'(SETTLE_CYC0 - 1);
            2'h1: v = shc_pkg::CNT_W'(SETTLE_CYC1 - 1);
            2'h2: v = shc_pkg::CNT_W'(SETTLE_CYC2 - 1);
            default: v = shc_pkg::CNT_W'(SETTLE_CYC3 - 1);
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st           = st;
        cnt_load          = 1'b0;
        cnt_val           = '0;
        next_st.osc_sync1 = osc_started_in;
        next_st.osc_sync2 = st.osc_sync1;
        next_st.wake_vec  = 1'b0;
        next_st.wake_next = 1'b0;
        next_st.rdata     = 8'h00;

        if (wr_in && addr_in == shc_pkg::REG_SETTLE_SELECT) begin
            next_st.settle_sel = {wdata_in[shc_pkg::SEL_HI_BIT], wdata_in[shc_pkg::SEL_LO_BIT]};
        end
        if (rd_in) begin
            case (addr_in)
                shc_pkg::REG_SETTLE_SELECT: begin
                    next_st.rdata = {6'h00, st.settle_sel};
                end
                shc_pkg::REG_STANDBY_STAT: begin
                    next_st.rdata[shc_pkg::STAT_HALT_BIT]   = (st.mode == shc_pkg::MODE_HALT);
                    next_st.rdata[shc_pkg::STAT_STOP_BIT]   = st.osc_stop;
                    next_st.rdata[shc_pkg::STAT_SETTLE_BIT] = (st.mode == shc_pkg::MODE_STOP_SETTLE);
                    next_st.rdata[shc_pkg::STAT_RUN_BIT]    = st.cpu_clk_en;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        case (st.mode)
            shc_pkg::MODE_BOOT_OSC: begin
                // reset out of stop: nothing starts before the oscillator runs
                if (osc_ok) begin
                    next_st.mode = shc_pkg::MODE_BOOT_OPT;
                    cnt_load     = 1'b1;
                    cnt_val      = shc_pkg::CNT_W'(OPTBYTE_CYC - 1);
                end
            end
            shc_pkg::MODE_BOOT_OPT: begin
                if (cnt_zero) begin
                    next_st.mode       = shc_pkg::MODE_RUN;
                    next_st.cpu_clk_en = 1'b1;
                end
            end
            shc_pkg::MODE_RUN: begin
                if (stop_cmd_in || halt_cmd_in) begin
                    next_st.port_hold  = 1'b1;
                    next_st.cpu_clk_en = 1'b0;
                    next_st.take_vec   = int_accept_enable_in;
                    if (int_pending_in && halt_cmd_in) begin
                        next_st.mode = shc_pkg::MODE_HALT_WAKE;
                        cnt_load     = 1'b1;
                        cnt_val      = int_accept_enable_in ? shc_pkg::CNT_W'(shc_pkg::WAKE_VEC_CLK - 1)
                                                            : shc_pkg::CNT_W'(shc_pkg::WAKE_NEXT_CLK - 1);
                    end else if (int_pending_in) begin
                        // oscillator never stopped, so only the stop time remains
                        next_st.mode = shc_pkg::MODE_STOP_HOLD;
                        cnt_load     = 1'b1;
                        cnt_val      = shc_pkg::CNT_W'(shc_pkg::STOP_HOLD_CYC - 1);
                    end else if (stop_cmd_in) begin
                        next_st.mode       = shc_pkg::MODE_STOP;
                        next_st.osc_stop   = 1'b1;
                        next_st.lsosc_keep = lsosc_on_in;
                    end else begin
                        next_st.mode = shc_pkg::MODE_HALT;
                    end
                end
            end
            shc_pkg::MODE_HALT: begin
                // masked requests never reach int_pending_in, so halt is held
                if (int_pending_in) begin
                    next_st.mode     = shc_pkg::MODE_HALT_WAKE;
                    next_st.take_vec = int_accept_enable_in;
                    cnt_load         = 1'b1;
                    cnt_val          = int_accept_enable_in ? shc_pkg::CNT_W'(shc_pkg::WAKE_VEC_CLK - 1)
                                                            : shc_pkg::CNT_W'(shc_pkg::WAKE_NEXT_CLK - 1);
                end
            end
            shc_pkg::MODE_HALT_WAKE, shc_pkg::MODE_STOP_HOLD: begin
                if (cnt_zero) begin
                    next_st.mode       = shc_pkg::MODE_RUN;
                    next_st.cpu_clk_en = 1'b1;
                    next_st.port_hold  = 1'b0;
                    next_st.wake_vec   = st.take_vec;
                    next_st.wake_next  = !st.take_vec;
                end
            end
            shc_pkg::MODE_STOP: begin
                if (int_pending_in) begin
                    next_st.mode       = shc_pkg::MODE_STOP_OSC;
                    next_st.osc_stop   = 1'b0;
                    next_st.lsosc_keep = 1'b0;
                    next_st.take_vec   = int_accept_enable_in;
                end
            end
            shc_pkg::MODE_STOP_OSC: begin
                // start-up time before the first oscillation is not counted
                if (osc_ok) begin
                    cnt_load = 1'b1;
                    if (clk_src_xtal_in) begin
                        next_st.mode = shc_pkg::MODE_STOP_SETTLE;
                        cnt_val      = settle_load(st.settle_sel);
                    end else begin
                        next_st.mode = shc_pkg::MODE_STOP_HOLD;
                        cnt_val      = shc_pkg::CNT_W'(shc_pkg::STOP_HOLD_CYC - 1);
                    end
                end
            end
            shc_pkg::MODE_STOP_SETTLE: begin
                if (cnt_zero) begin
                    next_st.mode = shc_pkg::MODE_STOP_HOLD;
                    cnt_load     = 1'b1;
                    cnt_val      = shc_pkg::CNT_W'(shc_pkg::STOP_HOLD_CYC - 1);
                end
            end
            default: begin
                next_st.mode = shc_pkg::MODE_BOOT_OSC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st            <= '0;
            st.mode       <= shc_pkg::MODE_BOOT_OSC;
            st.settle_sel <= shc_pkg::SETTLE_SEL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out      = st.rdata;
    assign cpu_clk_en_out = st.cpu_clk_en;
    assign osc_stop_out   = st.osc_stop;
    assign port_hold_out  = st.port_hold;
    assign lsosc_keep_out = st.lsosc_keep;
    assign wake_vec_out   = st.wake_vec;
    assign wake_next_out  = st.wake_next;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic is_run;
    assign is_run = (st.mode == shc_pkg::MODE_RUN);

    property p_stop_entry;
        is_run && stop_cmd_in && !int_pending_in |=> osc_stop_out && !cpu_clk_en_out;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop did not halt oscillator");

    property p_stop_hold;
        $rose(st.mode == shc_pkg::MODE_STOP_HOLD) |-> !cpu_clk_en_out [*8];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("cpu resumed inside stop time");

    property p_port_hold;
        (is_run && (halt_cmd_in || stop_cmd_in)) |=> port_hold_out until cpu_clk_en_out;
    endproperty
    a_port_hold: assert property (p_port_hold) else $error("port hold dropped in standby");

    property p_lsosc;
        is_run && stop_cmd_in && !int_pending_in && lsosc_on_in |=> lsosc_keep_out && osc_stop_out;
    endproperty
    a_lsosc: assert property (p_lsosc) else $error("low-speed oscillator not kept");

    property p_no_settle;
        st.mode == shc_pkg::MODE_STOP_OSC && osc_ok && !clk_src_xtal_in
            |=> st.mode == shc_pkg::MODE_STOP_HOLD;
    endproperty
    a_no_settle: assert property (p_no_settle) else $error("settle wait with non-crystal source");

    property p_osc_wait;
        st.mode == shc_pkg::MODE_STOP_OSC && !osc_ok |=> st.mode == shc_pkg::MODE_STOP_OSC;
    endproperty
    a_osc_wait: assert property (p_osc_wait) else $error("settle count before oscillation");

    property p_halt_entry;
        is_run && halt_cmd_in && !stop_cmd_in && !int_pending_in |=> !cpu_clk_en_out && !osc_stop_out;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");

    property p_immediate;
        is_run && (halt_cmd_in || stop_cmd_in) && int_pending_in |=> !osc_stop_out && !is_run;
    endproperty
    a_immediate: assert property (p_immediate) else $error("standby not left at once");

    property p_halt_held;
        st.mode == shc_pkg::MODE_HALT && !int_pending_in |=> st.mode == shc_pkg::MODE_HALT;
    endproperty
    a_halt_held: assert property (p_halt_held) else $error("halt left without request");

    property p_vec_wait;
        st.mode == shc_pkg::MODE_HALT && int_pending_in && int_accept_enable_in
            |-> ##[11:13] (cpu_clk_en_out && wake_vec_out);
    endproperty
    a_vec_wait: assert property (p_vec_wait) else $error("vectored halt wake timing");

    property p_next_wait;
        st.mode == shc_pkg::MODE_HALT && int_pending_in && !int_accept_enable_in
            |-> ##[3:5] (cpu_clk_en_out && wake_next_out);
    endproperty
    a_next_wait: assert property (p_next_wait) else $error("non-vectored halt wake timing");

    // boot, settle and wake pulse sequencing
    property p_boot_osc;
        st.mode == shc_pkg::MODE_BOOT_OSC && !osc_ok |=> st.mode == shc_pkg::MODE_BOOT_OSC;
    endproperty
    a_boot_osc: assert property (p_boot_osc) else $error("boot left before oscillation");

    property p_boot_opt;
        st.mode == shc_pkg::MODE_BOOT_OPT && !cnt_zero |=> !cpu_clk_en_out;
    endproperty
    a_boot_opt: assert property (p_boot_opt) else $error("cpu ran during option byte read");

    property p_boot_run;
        st.mode == shc_pkg::MODE_BOOT_OPT && cnt_zero |=> cpu_clk_en_out && !wake_vec_out && !wake_next_out;
    endproperty
    a_boot_run: assert property (p_boot_run) else $error("boot did not release cpu");

    property p_settle_src;
        $rose(st.mode == shc_pkg::MODE_STOP_SETTLE)
            |-> $past(st.mode == shc_pkg::MODE_STOP_OSC) && $past(clk_src_xtal_in);
    endproperty
    a_settle_src: assert property (p_settle_src) else $error("settle wait outside crystal stop release");

    property p_settle_hold;
        st.mode == shc_pkg::MODE_STOP_SETTLE && !cnt_zero
            |=> st.mode == shc_pkg::MODE_STOP_SETTLE && !cpu_clk_en_out;
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("settle left before terminal count");

    property p_settle_end;
        st.mode == shc_pkg::MODE_STOP_SETTLE && cnt_zero |=> st.mode == shc_pkg::MODE_STOP_HOLD;
    endproperty
    a_settle_end: assert property (p_settle_end) else $error("stop time skipped after settle");

    property p_wake_pulse;
        wake_vec_out || wake_next_out |-> (cpu_clk_en_out && !port_hold_out) ##1 (!wake_vec_out && !wake_next_out);
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse wrong");

    c_immediate: cover property (is_run && stop_cmd_in && int_pending_in);
    c_halt_wake: cover property (st.mode == shc_pkg::MODE_HALT ##1 st.mode == shc_pkg::MODE_HALT_WAKE);
    c_stop_settle: cover property ($rose(st.mode == shc_pkg::MODE_STOP_SETTLE));
    c_stop_plain: cover property (st.mode == shc_pkg::MODE_STOP_OSC ##1 st.mode == shc_pkg::MODE_STOP_HOLD);
    c_boot_done: cover property ($rose(cpu_clk_en_out) && !wake_vec_out && !wake_next_out);

endmodule

/* File: sim/shc_cpu_model.sv */
// shc_cpu_model: cpu core and oscillator start-up model facing the standby controller
module shc_cpu_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       cpu_clk_en_in,
    input  wire logic       osc_stop_in,
    input  wire logic       go_halt_in,
    input  wire logic       go_stop_in,
    input  wire logic       raise_int_in,
    input  wire logic [3:0] osc_delay_in,
    output logic            halt_cmd_out,
    output logic            stop_cmd_out,
    output logic            int_pending_out,
    output logic            osc_started_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] osc_cnt;

    // ------------------------------------------------------------
    // instruction issue
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            halt_cmd_out    <= 1'b0;
            stop_cmd_out    <= 1'b0;
            int_pending_out <= 1'b0;
        end else begin
            // peripherals and converter are already idle when these issue
            halt_cmd_out <= go_halt_in & cpu_clk_en_in;
            stop_cmd_out <= go_stop_in & cpu_clk_en_in;
            if (raise_int_in) begin
                int_pending_out <= 1'b1;
            end else if (cpu_clk_en_in) begin
                int_pending_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // oscillator start: dead while stopped, starts after a variable delay
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in || osc_stop_in) begin
            osc_cnt         <= 4'h0;
            osc_started_out <= 1'b0;
        end else if (osc_cnt != osc_delay_in) begin
            osc_cnt <= osc_cnt + 4'h1;
        end else begin
            osc_started_out <= 1'b1;
        end
    end
endmodule

/* File: sim/shc_standby_ctrl_tb.sv */
// shc_standby_ctrl_tb: self-checking bench for the standby controller
module shc_standby_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [1:0] pulse; bit from_osc; int lo; int hi;} shc_wake_type;
    localparam int SC [4] = '{16, 64, 128, 256};
    localparam int OPT    = 20;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [15:0] addr = 16'h0;
    logic [7:0]  wdata = 8'h0;
    logic        wr = 1'b0, rd = 1'b0, ie = 1'b0, xtal = 1'b1, lsosc = 1'b0;
    logic        go_halt = 1'b0, go_stop = 1'b0, raise_int = 1'b0;
    logic [3:0]  osc_delay = 4'h9;
    logic [7:0]  rdata;
    logic        clk_en, osc_stop, hold, lsk, wvec, wnext, halt_cmd, stop_cmd, int_pend, osc_ok;
    logic        rd_d = 1'b0, clk_en_d = 1'b0, int_d = 1'b0, osc_d = 1'b0;
    logic [7:0]  rd_q [$];
    logic [2:0]  ent_q [$];
    shc_wake_type wake_q [$];
    int          n_mismatch = 0, checked = 0, cycles = 0, since_int = 0, since_osc = 0, seed = 56, sel = 3;

    always #12.5 clk_in = ~clk_in;

    shc_standby_ctrl #(.SETTLE_CYC0(SC[0]), .SETTLE_CYC1(SC[1]), .SETTLE_CYC2(SC[2]), .SETTLE_CYC3(SC[3]),
                       .OPTBYTE_CYC(OPT)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .halt_cmd_in(halt_cmd), .stop_cmd_in(stop_cmd), .int_pending_in(int_pend),
        .int_accept_enable_in(ie), .clk_src_xtal_in(xtal), .lsosc_on_in(lsosc), .osc_started_in(osc_ok),
        .rdata_out(rdata), .cpu_clk_en_out(clk_en), .osc_stop_out(osc_stop), .port_hold_out(hold),
        .lsosc_keep_out(lsk), .wake_vec_out(wvec), .wake_next_out(wnext));

    shc_cpu_model cpu_u (
        .clk_in(clk_in), .rst_in(rst_in), .cpu_clk_en_in(clk_en), .osc_stop_in(osc_stop),
        .go_halt_in(go_halt), .go_stop_in(go_stop), .raise_int_in(raise_int), .osc_delay_in(osc_delay),
        .halt_cmd_out(halt_cmd), .stop_cmd_out(stop_cmd), .int_pending_out(int_pend),
        .osc_started_out(osc_ok));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
    endtask

    task automatic note_wake(input logic [1:0] p, input bit o, input int lo, input int span);
        shc_wake_type w;
        w.pulse    = p;
        w.from_osc = o;
        w.lo       = lo;
        w.hi       = lo + span;
        wake_q.push_back(w);
    endtask

    task automatic wait_run();
        int k;
        k = 0;
        while (clk_en !== 1'b1 && k < 5000) begin
            @(negedge clk_in);
            k++;
        end
        if (k >= 5000) check("wake wait", 32'h1, 32'h0);
        repeat (3) @(posedge clk_in);
    endtask

    // enter standby, sit idle with no request, then wake by interrupt or reset
    task automatic sleep(input bit stop, input bit v, input bit ls, input bit by_reset);
        @(posedge clk_in);
        ie        <= v;
        lsosc     <= ls;
        osc_delay <= 4'h8 | 4'($random(seed));
        ent_q.push_back({stop, 1'b1, stop & ls});
        if (stop) go_stop <= 1'b1;
        else go_halt <= 1'b1;
        @(posedge clk_in);
        go_stop <= 1'b0;
        go_halt <= 1'b0;
        repeat (40) @(posedge clk_in);
        rd_reg(shc_pkg::REG_STANDBY_STAT, stop ? 8'h02 : 8'h01);
        if (by_reset) begin
            note_wake(2'b00, 1'b1, OPT, 6);
            @(posedge clk_in);
            rst_in <= 1'b1;
            repeat (6) @(posedge clk_in);
            rst_in <= 1'b0;
            sel = 3;
        end else begin
            if (stop) note_wake({v, ~v}, 1'b1, (xtal ? SC[sel] : 0) + shc_pkg::STOP_HOLD_CYC, 6);
            else note_wake({v, ~v}, 1'b0, 1 + (v ? shc_pkg::WAKE_VEC_CLK : shc_pkg::WAKE_NEXT_CLK), 0);
            @(posedge clk_in);
            raise_int <= 1'b1;
            @(posedge clk_in);
            raise_int <= 1'b0;
        end
        wait_run();
        $display("test standby stop=%0d vec=%0d reset=%0d done", stop, v, by_reset);
    endtask

    // command while an unmasked request already pends: standby is left at once
    task automatic sleep_now(input bit stop, input bit v);
        @(posedge clk_in);
        ie <= v;
        ent_q.push_back(3'b010);
        note_wake({v, ~v}, 1'b0, 1 + (stop ? shc_pkg::STOP_HOLD_CYC
                                           : v ? shc_pkg::WAKE_VEC_CLK : shc_pkg::WAKE_NEXT_CLK), 0);
        raise_int <= 1'b1;
        if (stop) go_stop <= 1'b1;
        else go_halt <= 1'b1;
        @(posedge clk_in);
        raise_int <= 1'b0;
        go_stop   <= 1'b0;
        go_halt   <= 1'b0;
        // clock enable only drops at the edge after the command reaches the block
        repeat (2) @(posedge clk_in);
        wait_run();
        $display("test pending stop=%0d vec=%0d done", stop, v);
    endtask

    // ------------------------------------------------------------
    // monitor: compares every result against the oldest note
    // ------------------------------------------------------------
    always @(posedge clk_in) rd_d <= rd;

    always @(negedge clk_in) begin
        shc_wake_type w;
        int           lat;
        since_int++;
        since_osc++;
        if (int_pend && !int_d) since_int = 0;
        if (osc_ok && !osc_d) since_osc = 0;
        if (rd_d) begin
            if (rd_q.size() == 0) check("read strobe", 32'h0, 32'h1);
            else check("read data", rd_q.pop_front(), rdata);
        end
        if (!clk_en && clk_en_d && ent_q.size() != 0) check("standby outputs", ent_q.pop_front(), {osc_stop, hold, lsk});
        if (clk_en && !clk_en_d) begin
            if (wake_q.size() == 0) check("cpu clock", 32'h0, 32'h1);
            else begin
                w   = wake_q.pop_front();
                lat = w.from_osc ? since_osc : since_int;
                check("wake pulse", w.pulse, {wvec, wnext});
                check("wake latency", (lat >= w.lo && lat <= w.hi) ? lat : w.lo, lat);
                check("hold release", 32'h0, {osc_stop, hold});
            end
        end
        int_d    = int_pend;
        osc_d    = osc_ok;
        clk_en_d = clk_en;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            check("cycle limit", 32'h0, 32'h1);
            test_done();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        note_wake(2'b00, 1'b1, OPT, 6);
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_reg(shc_pkg::REG_SETTLE_SELECT, {6'h0, shc_pkg::SETTLE_SEL_RESET});
        wait_run();
        rd_reg(shc_pkg::REG_STANDBY_STAT, 8'h08);
        rd_reg(16'hfff6, 8'h00);
        wr_reg(shc_pkg::REG_STANDBY_STAT, 8'hff);
        rd_reg(shc_pkg::REG_STANDBY_STAT, 8'h08);
        repeat (4) begin
            r = $random(seed);
            wr_reg(shc_pkg::REG_SETTLE_SELECT, r[7:0]);
            rd_reg(shc_pkg::REG_SETTLE_SELECT, {6'h0, r[1:0]});
        end
        $display("test registers done");
        sleep(1'b0, 1'b1, 1'b1, 1'b0);
        sleep(1'b0, 1'b0, 1'b0, 1'b0);
        sleep_now(1'b0, 1'b1);
        sleep_now(1'b1, 1'b0);
        for (int s = 0; s < 4; s++) begin
            sel = s;
            wr_reg(shc_pkg::REG_SETTLE_SELECT, 8'(s));
            sleep(1'b1, s[0], s[1], 1'b0);
        end
        xtal <= 1'b0;
        sleep(1'b1, 1'b1, 1'b1, 1'b0);
        xtal <= 1'b1;
        sleep(1'b0, 1'b1, 1'b0, 1'b1);
        sleep(1'b1, 1'b0, 1'b1, 1'b1);
        test_done();
    end
endmodule
